// File: rtl/sleep_serial_pkg.sv
/*
  constants, register map and pin carriers of the sleep capable
  synchronous slave serial port.
  assumes a 32-bit avalon-mm register bus with byte addresses.
*/
package sleep_serial_pkg;

  // bus geometry
  localparam int ADDR_W = 6;
  localparam int DATA_W = 32;
  localparam int WORD_W = 8;
  localparam int RX_DEPTH_DEF = 2;
  localparam int LOCS = 2;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_ALT_PIN  = 6'h00;
  localparam logic [ADDR_W-1:0] OFF_BAUD     = 6'h04;
  localparam logic [ADDR_W-1:0] OFF_GLB_IRQ  = 6'h08;
  localparam logic [ADDR_W-1:0] OFF_PIE      = 6'h0c;
  localparam logic [ADDR_W-1:0] OFF_PIR      = 6'h10;
  localparam logic [ADDR_W-1:0] OFF_RX_DATA  = 6'h14;
  localparam logic [ADDR_W-1:0] OFF_RX_STAT  = 6'h18;
  localparam logic [ADDR_W-1:0] OFF_TX_STAT  = 6'h1c;
  localparam logic [ADDR_W-1:0] OFF_TX_DATA  = 6'h20;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 6'h24;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 6'h28;

  // field positions
  localparam int TSC_CLOCK_SOURCE_SELECT   = 7;
  localparam int TSC_TXEN   = 5;
  localparam int TSC_SYNC   = 4;
  localparam int TSC_TRMT   = 1;
  localparam int RSC_PORT_ENABLE   = 7;
  localparam int RSC_SINGLE_RECEIVE_ENABLE   = 5;
  localparam int RSC_CONTINUOUS_RECEIVE_ENABLE   = 4;
  localparam int RSC_OVERRUN_ERROR   = 1;
  localparam int BAUD_RCIDL = 6;
  localparam int BAUD_SCKP  = 4;
  localparam int GIC_GIE    = 7;
  localparam int GIC_PERIPHERAL_IRQ_ENABLE   = 6;
  localparam int PI_RX      = 5;
  localparam int PI_TX      = 4;
  localparam int APS_TXSEL  = 2;
  localparam int APS_RXSEL  = 1;
  localparam int IRQ_RX     = 0;
  localparam int IRQ_TX     = 1;
  localparam int IRQ_OVR    = 2;

  // writable bits of each register, the rest reads zero except the status bits (TRMT, RCIDL, overrun)
  localparam logic [7:0] TSC_RW  = 8'hfd;
  localparam logic [7:0] RSC_RW  = 8'hf8;
  localparam logic [7:0] BAUD_RW = 8'h9b;
  localparam logic [7:0] GIC_RW  = 8'hc0;
  localparam logic [7:0] PIE_RW  = 8'h30;
  localparam logic [7:0] APS_RW  = 8'h06;
  localparam logic [7:0] IRQ_RW  = 8'h07;

  // values after reset
  localparam logic [7:0]  REG_RST    = 8'h00;
  localparam logic [15:0] ISR_VECTOR = 16'h0004;

  // one pin location as seen from outside
  typedef struct packed {
    logic dat;
    logic clk;
  } pin_in_t;

  typedef struct packed {
    logic dat;
    logic dat_oe_n;
    logic clk;
    logic clk_oe_n;
  } pin_out_t;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_SHIFT = 2'b01
  } tx_state_t;

endpackage

// File: rtl/pin_sync.sv
/*
  two flip-flop synchroniser for a vector of independent levels.
  assumes each bit is a slow level; no bit relation is kept.
*/
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             clock_i,
  input  wire logic             rstn_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;

  // first stage feeds only the second
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule // pin_sync

// File: rtl/sleep_serial.sv
/*
  synchronous slave serial port that keeps shifting while the core
  sleeps, with avalon-mm registers, wake and interrupt outputs.
  assumes the link clock pin toggles far slower than clock_i and that
  the external master owns the clock pin.
*/
// Implementation choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps

// How it works
// RL1: only synchronous slave mode keeps running asleep
// RL2: shift registers advance on external link clock
// RL3: reading receive data pops buffer, clears flag
// RL4: receive wake needs enables set beforehand
// RL5: master drives data and clock to receive
// RL6: complete word sets receive pending flag, wakes
// RL7: wake runs on; global enable vectors to 004h
// RL8: transmit write clears flag, fills shift first
// RL9: software sets transmit and peripheral enables
// RL10: device drives data in step with clock
// RL11: shift empty reloads from buffer, sets flag
// RL12: free buffer accepts write, clears empty flag
// RL13: pins relocatable, default locations after reset
// RL14: unimplemented register bits read as zero
// RL15: slave mode set by sync, clock_source_select, enable
// RL16: continuous receive stays on, single receive ignored (single receive still blocks tx_mode here)
// RL17: overrun cleared by receive or port disable
// RL18: link clock events synchronised into core clock
module sleep_serial
  import sleep_serial_pkg::*;
#(
  parameter int RX_DEPTH = sleep_serial_pkg::RX_DEPTH_DEF
) (
  input  wire logic                                      clock_i,
  input  wire logic                                      rstn_i,
  input  wire logic [sleep_serial_pkg::ADDR_W-1:0]       address_i,
  input  wire logic                                      read_i,
  input  wire logic                                      write_i,
  input  wire logic [sleep_serial_pkg::DATA_W-1:0]       writedata_i,
  output logic      [sleep_serial_pkg::DATA_W-1:0]       readdata_o,
  output logic                                           waitrequest_o,
  input  wire sleep_serial_pkg::pin_in_t  [sleep_serial_pkg::LOCS-1:0] pins_i,
  output sleep_serial_pkg::pin_out_t      [sleep_serial_pkg::LOCS-1:0] pins_o,
  input  wire logic                                      sleep_i,
  output logic                                           irq_o,
  output logic                                           wake_o,
  output logic                                           vector_req_o,
  output logic      [15:0]                               vector_addr_o
);
  import sleep_serial_pkg::*;

  localparam int PTR_W = (RX_DEPTH > 1) ? $clog2(RX_DEPTH) : 1;
  localparam int CNT_W = $clog2(RX_DEPTH + 1);
  localparam int BIT_W = $clog2(WORD_W);
  localparam logic [CNT_W-1:0] FIFO_FULL = CNT_W'(RX_DEPTH);
  localparam logic [BIT_W-1:0] LAST_BIT  = BIT_W'(WORD_W - 1);

  // software registers
  logic [7:0]        aps_q, baud_q, gic_q, pie_q, tsc_q, rsc_q, irq_stat_q, irq_mask_q;
  // bus slave state
  logic              wait_q, req, acc;
  logic [DATA_W-1:0] rdata_q;
  logic [7:0]        rd_mux, wbyte;
  // link side
  logic [2*LOCS-1:0] pins_raw, pins_s;
  logic              clk_s, dat_s, clk_prev_q, sample_edge;
  // mode decode
  logic              link_run, rx_mode, tx_mode;
  // receiver
  logic [WORD_W-1:0] rsr_q;
  logic [WORD_W-1:0] rx_mem_q [RX_DEPTH];
  logic [BIT_W-1:0]  rx_cnt_q;
  logic [PTR_W-1:0]  rd_ptr_q, wr_ptr;
  logic [CNT_W-1:0]  rx_cnt_fifo_q;
  logic              overrun_error_q, rx_done, rx_push, rx_pop, rx_pending_flag;
  // transmitter
  tx_state_t         tx_state_q;
  logic [WORD_W-1:0] tsr_q, txbuf_q;
  logic [BIT_W-1:0]  tx_cnt_q;
  logic              txbuf_full_q, tx_load, tx_buffer_empty_flag;
  // interrupt and wake
  logic [7:0]        irq_evt, irq_clr;
  logic              pending;

  // accepted write to an offset, accepted read of receive data
  function automatic logic wr_hit(input logic [ADDR_W-1:0] off);
    return acc & write_i & (address_i == off);
  endfunction
  function automatic logic wr_hit_rd();
    return acc & read_i & (address_i == OFF_RX_DATA);
  endfunction

  // bus handshake: one wait cycle, then accept
  assign req   = read_i | write_i;
  assign acc   = req & ~wait_q;
  assign wbyte = writedata_i[7:0];

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= ~(req & wait_q);
    end
  end

  // read data captured while waitrequest is still high
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_q <= '0;
    end else if (read_i && wait_q) begin
      rdata_q <= {{(DATA_W-8){1'b0}}, rd_mux};
    end
  end
  assign readdata_o    = rdata_q;
  assign waitrequest_o = wait_q;

  // RL14 read masking
  always_comb begin
    rd_mux = 8'h00;
    case (address_i)
      OFF_ALT_PIN:  rd_mux = aps_q;
      OFF_BAUD: begin
        rd_mux = baud_q;
        rd_mux[BAUD_RCIDL] = ~rx_mode | (rx_cnt_q == '0);
      end
      OFF_GLB_IRQ:  rd_mux = gic_q;
      OFF_PIE:      rd_mux = pie_q;
      OFF_PIR: begin
        rd_mux[PI_RX] = rx_pending_flag;
        rd_mux[PI_TX] = tx_buffer_empty_flag;
      end
      OFF_RX_DATA:  rd_mux = (rx_cnt_fifo_q != '0) ? rx_mem_q[rd_ptr_q] : 8'h00;
      OFF_RX_STAT: begin
        rd_mux = rsc_q;
        rd_mux[RSC_OVERRUN_ERROR] = overrun_error_q;
      end
      OFF_TX_STAT: begin
        rd_mux = tsc_q;
        rd_mux[TSC_TRMT] = (tx_state_q == TX_IDLE);
      end
      OFF_IRQ_STAT: rd_mux = irq_stat_q;
      OFF_IRQ_MASK: rd_mux = irq_mask_q;
      default:      rd_mux = 8'h00;
    endcase
  end

  // RL13 pin location select, RL14 writable bits only
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      aps_q  <= REG_RST;
      baud_q <= REG_RST;
      gic_q  <= REG_RST;
      pie_q  <= REG_RST;
    end else begin
      if (wr_hit(OFF_ALT_PIN)) aps_q  <= wbyte & APS_RW;
      if (wr_hit(OFF_BAUD))    baud_q <= wbyte & BAUD_RW;
      if (wr_hit(OFF_GLB_IRQ)) gic_q  <= wbyte & GIC_RW;
      if (wr_hit(OFF_PIE))     pie_q  <= wbyte & PIE_RW;
    end
  end

  // control registers of the port
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tsc_q      <= REG_RST;
      rsc_q      <= REG_RST;
      irq_mask_q <= REG_RST;
    end else begin
      if (wr_hit(OFF_TX_STAT))  tsc_q      <= wbyte & TSC_RW;
      if (wr_hit(OFF_RX_STAT))  rsc_q      <= wbyte & RSC_RW;
      if (wr_hit(OFF_IRQ_MASK)) irq_mask_q <= wbyte & IRQ_RW;
    end
  end

  // RL15 slave mode decode
  // RL1 master and asynchronous modes never shift here
  assign link_run = rsc_q[RSC_PORT_ENABLE] & tsc_q[TSC_SYNC] & ~tsc_q[TSC_CLOCK_SOURCE_SELECT];
  // RL16 single receive enable is a don't care for rx_mode, but it blocks tx_mode
  assign rx_mode  = link_run & rsc_q[RSC_CONTINUOUS_RECEIVE_ENABLE];
  assign tx_mode  = link_run & tsc_q[TSC_TXEN] & ~rsc_q[RSC_CONTINUOUS_RECEIVE_ENABLE] & ~rsc_q[RSC_SINGLE_RECEIVE_ENABLE];

  // RL18 pins pass two flops before use
  for (genvar l = 0; l < LOCS; l++) begin : g_raw
    assign pins_raw[2*l]   = pins_i[l].clk;
    assign pins_raw[2*l+1] = pins_i[l].dat;
  end

  pin_sync #(.WIDTH(2*LOCS)) u_pin_sync (
    .clock_i (clock_i),
    .rstn_i  (rstn_i),
    .async_i (pins_raw),
    .sync_o  (pins_s)
  );

  // RL13 alternate location picks the synced pins
  assign clk_s = aps_q[APS_TXSEL] ? pins_s[2] : pins_s[0];
  assign dat_s = aps_q[APS_RXSEL] ? pins_s[3] : pins_s[1];

  // RL18 edge found on the synced clock only
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      clk_prev_q <= 1'b0;
    end else begin
      clk_prev_q <= clk_s;
    end
  end

  // RL2 the master's clock is the only shift source
  assign sample_edge = (clk_prev_q ^ baud_q[BAUD_SCKP]) & ~(clk_s ^ baud_q[BAUD_SCKP]);
  // RL5 a word completes after eight master clocks
  assign rx_done = rx_mode & sample_edge & ~overrun_error_q & (rx_cnt_q == LAST_BIT);
  assign rx_push = rx_done & (rx_cnt_fifo_q != FIFO_FULL);
  // RL3 read of receive data pops the buffer
  assign rx_pop  = wr_hit_rd() & (rx_cnt_fifo_q != '0);
  assign wr_ptr  = PTR_W'((CNT_W+PTR_W)'(rd_ptr_q) + (CNT_W+PTR_W)'(rx_cnt_fifo_q));
  assign rx_pending_flag    = (rx_cnt_fifo_q != '0);

  // receive shift register, lsb first
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rsr_q    <= '0;
      rx_cnt_q <= '0;
    end else if (!rx_mode) begin
      rx_cnt_q <= '0;
    end else if (sample_edge && !overrun_error_q) begin
      rsr_q    <= {dat_s, rsr_q[WORD_W-1:1]};
      rx_cnt_q <= (rx_cnt_q == LAST_BIT) ? '0 : rx_cnt_q + 1'b1;
    end
  end

  // RL6 finished word lands in the buffer
  always_ff @(posedge clock_i) begin
    if (rx_push) begin
      rx_mem_q[wr_ptr] <= {dat_s, rsr_q[WORD_W-1:1]};
    end
  end

  // buffer occupancy; port disable empties it
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rd_ptr_q      <= '0;
      rx_cnt_fifo_q <= '0;
    end else if (!rsc_q[RSC_PORT_ENABLE]) begin
      rd_ptr_q      <= '0;
      rx_cnt_fifo_q <= '0;
    end else begin
      if (rx_pop) begin
        rd_ptr_q <= (rd_ptr_q == PTR_W'(RX_DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
      end
      rx_cnt_fifo_q <= rx_cnt_fifo_q + CNT_W'(rx_push) - CNT_W'(rx_pop);
    end
  end

  // RL17 overrun held until receive or port disabled
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      overrun_error_q <= 1'b0;
    end else if (!rsc_q[RSC_CONTINUOUS_RECEIVE_ENABLE] || !rsc_q[RSC_PORT_ENABLE]) begin
      overrun_error_q <= 1'b0;
    end else if (rx_done && !rx_push) begin
      overrun_error_q <= 1'b1;
    end
  end

  // RL8 buffer moves to an idle shift register
  assign tx_load = tx_mode & txbuf_full_q & (tx_state_q == TX_IDLE);
  assign tx_buffer_empty_flag    = ~txbuf_full_q;
  // RL12 write taken only while the buffer is free
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      txbuf_q      <= '0;
      txbuf_full_q <= 1'b0;
    end else if (!rsc_q[RSC_PORT_ENABLE]) begin
      txbuf_full_q <= 1'b0;
    end else if (wr_hit(OFF_TX_DATA) && !txbuf_full_q) begin
      txbuf_q      <= wbyte;
      txbuf_full_q <= 1'b1;
    end else if (tx_load) begin
      txbuf_full_q <= 1'b0;
    end
  end

  // RL11 shift empty reloads from the buffer
  // RL10 one bit leaves per master clock
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_state_q <= TX_IDLE;
      tsr_q      <= '0;
      tx_cnt_q   <= '0;
    end else begin
      case (tx_state_q)
        TX_IDLE: begin
          if (tx_load) begin
            tsr_q      <= txbuf_q;
            tx_cnt_q   <= '0;
            tx_state_q <= TX_SHIFT;
          end
        end
        TX_SHIFT: begin
          if (!tx_mode) begin
            tx_state_q <= TX_IDLE;
          end else if (sample_edge) begin
            tsr_q    <= {1'b0, tsr_q[WORD_W-1:1]};
            tx_cnt_q <= tx_cnt_q + 1'b1;
            if (tx_cnt_q == LAST_BIT) begin
              tx_state_q <= TX_IDLE;
            end
          end
        end
        default: tx_state_q <= TX_IDLE;
      endcase
    end
  end

  // RL10 data pin driven at the chosen location
  // RL13 clock pin is only ever an input here
  for (genvar l = 0; l < LOCS; l++) begin : g_pin
    always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
        pins_o[l] <= '{dat: 1'b0, dat_oe_n: 1'b1, clk: 1'b0, clk_oe_n: 1'b1};
      end else begin
        pins_o[l].dat      <= tsr_q[0];
        pins_o[l].dat_oe_n <= ~(tx_mode & (aps_q[APS_RXSEL] == 1'(l)));
        pins_o[l].clk      <= 1'b0;
        pins_o[l].clk_oe_n <= 1'b1;
      end
    end
  end

  // sticky event bits, set wins over write-one clear
  always_comb begin
    irq_evt          = 8'h00;
    irq_evt[IRQ_RX]  = rx_push;
    irq_evt[IRQ_TX]  = tx_load;
    irq_evt[IRQ_OVR] = rx_done & ~rx_push;
    irq_clr          = wr_hit(OFF_IRQ_STAT) ? (wbyte & IRQ_RW) : 8'h00;
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_stat_q <= REG_RST;
      irq_o      <= 1'b0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_evt;
      irq_o      <= |(irq_stat_q & irq_mask_q);
    end
  end

  // RL4 enabled flags raise the peripheral request
  // RL9 transmit wake relies on software enables
  assign pending = gic_q[GIC_PERIPHERAL_IRQ_ENABLE] & ((rx_pending_flag & pie_q[PI_RX]) | (tx_buffer_empty_flag & pie_q[PI_TX]));

  // RL7 wake resumes; global enable adds the vector
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wake_o        <= 1'b0;
      vector_req_o  <= 1'b0;
      vector_addr_o <= ISR_VECTOR;
    end else begin
      wake_o        <= sleep_i & pending;
      vector_req_o  <= pending & gic_q[GIC_GIE];
      vector_addr_o <= ISR_VECTOR;
    end
  end

endmodule // sleep_serial

// File: sim/sleep_serial_chk.sv
/*
  checker for the sleep serial port: bus answer, read data and pins.
  assumes it is bound onto sleep_serial and sees only its ports.
*/
`timescale 1ns/1ps
module sleep_serial_chk
  import sleep_serial_pkg::*;
#(
  parameter int RX_DEPTH = 2
) (
  input wire logic                 clock_i,
  input wire logic                 rstn_i,
  input wire logic [ADDR_W-1:0]    address_i,
  input wire logic                 read_i,
  input wire logic                 write_i,
  input wire logic [DATA_W-1:0]    writedata_i,
  input wire logic [DATA_W-1:0]    readdata_o,
  input wire logic                 waitrequest_o,
  input wire pin_in_t  [LOCS-1:0]  pins_i,
  input wire pin_out_t [LOCS-1:0]  pins_o,
  input wire logic                 sleep_i,
  input wire logic                 irq_o,
  input wire logic                 wake_o,
  input wire logic                 vector_req_o,
  input wire logic [15:0]          vector_addr_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);

  // a request standing while the slave still waits
  sequence req_seen;
    (read_i || write_i) && waitrequest_o;
  endsequence
  // one accepting cycle, then wait again
  sequence one_accept;
    !waitrequest_o ##1 waitrequest_o;
  endsequence

  a_wait_once: assert property (req_seen |=> one_accept)
    else $error("bus answer not after one wait cycle");
  a_upper_zero: assert property (read_i && !waitrequest_o |-> readdata_o[31:8] == 24'h0)
    else $error("unused read bits not zero");
  a_unmapped_zero: assert property (read_i && !waitrequest_o && address_i > OFF_IRQ_MASK |-> readdata_o == 32'h0)
    else $error("unmapped read not zero");
  a_wo_reads_zero: assert property (read_i && !waitrequest_o && address_i == OFF_TX_DATA |-> readdata_o == 32'h0)
    else $error("transmit data read not zero");
  a_vector_addr: assert property (vector_addr_o == 16'h0004)
    else $error("vector address wrong");
  a_wake_asleep: assert property (!sleep_i |=> !wake_o)
    else $error("wake raised while awake");
  a_clk_released: assert property (pins_o[0].clk_oe_n && pins_o[1].clk_oe_n)
    else $error("clock pin driven");
  a_one_location: assert property (pins_o[0].dat_oe_n || pins_o[1].dat_oe_n)
    else $error("data driven at both locations");
endmodule // sleep_serial_chk

bind sleep_serial sleep_serial_chk #(.RX_DEPTH(RX_DEPTH)) i_sleep_serial_chk (
  .clock_i, .rstn_i, .address_i, .read_i, .write_i, .writedata_i, .readdata_o, .waitrequest_o,
  .pins_i, .pins_o, .sleep_i, .irq_o, .wake_o, .vector_req_o, .vector_addr_o
);

// File: sim/link_master.sv
/*
  behavioural synchronous master of the serial link.
  assumes the bench picks the pin location; paced by the core clock.
*/
`timescale 1ns/1ps
module link_master
  import sleep_serial_pkg::*;
(
  input  wire logic                  clock_i,
  input  wire logic                  loc_i,
  input  wire pin_out_t [LOCS-1:0]   dev_i,
  output pin_in_t       [LOCS-1:0]   line_o
);
  logic clk_q = 1'b1;
  logic drv_q = 1'b0;
  logic dat_q = 1'b0;
  logic junk_q = 1'b0;

  // a released data line shows a changing pattern
  always @(posedge clock_i) junk_q <= ~junk_q;

  // wire level of each location from both drivers
  always_comb begin
    for (int l = 0; l < LOCS; l++) begin
      line_o[l].clk = (l == int'(loc_i)) ? clk_q : 1'b1;
      if (!dev_i[l].dat_oe_n) line_o[l].dat = dev_i[l].dat;
      else if (drv_q && l == int'(loc_i)) line_o[l].dat = dat_q;
      else line_o[l].dat = junk_q;
    end
  end

  // one word each way, lsb first, clock idles high, 400 ns period
  task automatic xfer(input logic drive, input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 0; i < WORD_W; i++) begin
      // data set while clock is high
      dat_q <= tx[i];
      drv_q <= drive;
      repeat (2) @(posedge clock_i);
      // device bit taken at falling edge
      rx[i] = line_o[loc_i].dat;
      clk_q <= 1'b0;
      repeat (4) @(posedge clock_i);
      clk_q <= 1'b1;
      // data held past the rising edge too
      repeat (2) @(posedge clock_i);
    end
    drv_q <= 1'b0;
    @(posedge clock_i);
  endtask
endmodule // link_master

// File: sim/test_sleep_serial.sv
/*
  testbench of the sleep serial port: registers, receive, transmit, pins.
  assumes link_master on the pins and the checker bound to the design.
*/
`timescale 1ns/1ps
module test_sleep_serial;
  import sleep_serial_pkg::*;
  logic                  clock_i;
  logic                  rstn_i;
  logic [ADDR_W-1:0]     address_i;
  logic                  read_i;
  logic                  write_i;
  logic [DATA_W-1:0]     writedata_i;
  logic [DATA_W-1:0]     readdata_o;
  logic                  waitrequest_o;
  pin_in_t  [LOCS-1:0]   pins_i;
  pin_out_t [LOCS-1:0]   pins_o;
  logic                  sleep_i;
  logic                  irq_o;
  logic                  wake_o;
  logic                  vector_req_o;
  logic [15:0]           vector_addr_o;
  logic                  loc_q;
  int                    n_mismatch = 0;
  int                    samples_checked = 0;
  int                    cyc = 0;
  localparam logic [ADDR_W-1:0] RST_OFF [12] = '{OFF_ALT_PIN, OFF_BAUD, OFF_GLB_IRQ, OFF_PIE, OFF_PIR,
    OFF_RX_DATA, OFF_RX_STAT, OFF_TX_STAT, OFF_TX_DATA, OFF_IRQ_STAT, OFF_IRQ_MASK, 6'h3c};
  localparam logic [7:0] RST_VAL [12] = '{8'h00, 8'h40, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00, 8'h02, 8'h00,
    8'h00, 8'h00, 8'h00};
  localparam logic [ADDR_W-1:0] RW_OFF [7] = '{OFF_ALT_PIN, OFF_BAUD, OFF_GLB_IRQ, OFF_PIE, OFF_IRQ_MASK,
    OFF_RX_STAT, 6'h3c};
  localparam logic [7:0] RW_MSK [7] = '{APS_RW, BAUD_RW | 8'h40, GIC_RW, PIE_RW, IRQ_RW, RSC_RW, 8'h00};

  sleep_serial #(.RX_DEPTH(2)) i_sleep_serial (.clock_i, .rstn_i, .address_i, .read_i, .write_i,
    .writedata_i, .readdata_o, .waitrequest_o, .pins_i, .pins_o, .sleep_i, .irq_o, .wake_o,
    .vector_req_o, .vector_addr_o);
  link_master i_link_master (.clock_i, .loc_i(loc_q), .dev_i(pins_o), .line_o(pins_i));

  // 20 mhz core clock
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end

  task automatic wrap_up();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // hang guard
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s got %b", $time, what, got);
    end
  endtask

  // avalon accesses hold until waitrequest is seen low
  task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    address_i <= a;
    writedata_i <= {24'h0, d};
    write_i <= 1'b1;
    @(posedge clock_i);
    while (waitrequest_o !== 1'b0) @(posedge clock_i);
    write_i <= 1'b0;
    @(posedge clock_i);
  endtask
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] exp, input string what);
    address_i <= a;
    read_i <= 1'b1;
    @(posedge clock_i);
    while (waitrequest_o !== 1'b0) @(posedge clock_i);
    chk_byte(readdata_o[7:0], exp, what);
    read_i <= 1'b0;
    @(posedge clock_i);
  endtask
  task automatic wait_wake();
    for (int n = 0; n < 40 && wake_o !== 1'b1; n++) @(posedge clock_i);
    @(posedge clock_i);
  endtask

  // main sequence
  initial begin
    logic [7:0] v;
    rstn_i = 1'b0;
    read_i = 1'b0;
    write_i = 1'b0;
    address_i = '0;
    writedata_i = '0;
    sleep_i = 1'b0;
    loc_q = 1'b0;
    repeat (2) @(posedge clock_i);
    rstn_i <= 1'b1;
    @(posedge clock_i);
    for (int i = 0; i < 12; i++) rd_chk(RST_OFF[i], RST_VAL[i], "reset value");
    for (int i = 0; i < 7; i++) begin
      bus_wr(RW_OFF[i], 8'hff);
      rd_chk(RW_OFF[i], RW_MSK[i], "writable bits");
      bus_wr(RW_OFF[i], 8'h00);
    end
    $display("test regs done");
    bus_wr(OFF_TX_STAT, 8'h10);
    bus_wr(OFF_RX_STAT, 8'hb0);
    bus_wr(OFF_PIE, 8'h20);
    bus_wr(OFF_GLB_IRQ, 8'h40);
    bus_wr(OFF_IRQ_MASK, 8'h01);
    sleep_i <= 1'b1;
    i_link_master.xfer(1'b1, 8'ha5, v);
    wait_wake();
    chk_bit(wake_o, 1'b1, "rx wake");
    chk_bit(irq_o, 1'b1, "rx irq");
    chk_bit(vector_req_o, 1'b0, "no vector");
    sleep_i <= 1'b0;
    rd_chk(OFF_PIR, 8'h30, "rx pending");
    rd_chk(OFF_RX_DATA, 8'ha5, "rx word");
    rd_chk(OFF_PIR, 8'h10, "rx drained");
    chk_bit(wake_o, 1'b0, "awake");
    bus_wr(OFF_GLB_IRQ, 8'hc0);
    sleep_i <= 1'b1;
    i_link_master.xfer(1'b1, 8'h3c, v);
    wait_wake();
    chk_bit(vector_req_o, 1'b1, "vector");
    i_link_master.xfer(1'b1, 8'h5a, v);
    i_link_master.xfer(1'b1, 8'h0f, v);
    repeat (8) @(posedge clock_i);
    rd_chk(OFF_RX_STAT, 8'hb2, "overrun");
    rd_chk(OFF_RX_DATA, 8'h3c, "rx first");
    rd_chk(OFF_RX_DATA, 8'h5a, "rx second");
    rd_chk(OFF_IRQ_STAT, 8'h05, "events");
    bus_wr(OFF_IRQ_STAT, 8'h07);
    rd_chk(OFF_IRQ_STAT, 8'h00, "events cleared");
    chk_bit(irq_o, 1'b0, "irq cleared");
    bus_wr(OFF_RX_STAT, 8'h80);
    rd_chk(OFF_RX_STAT, 8'h80, "overrun cleared");
    sleep_i <= 1'b0;
    $display("test rx done");
    bus_wr(OFF_TX_STAT, 8'h30);
    bus_wr(OFF_PIE, 8'h10);
    bus_wr(OFF_GLB_IRQ, 8'h40);
    bus_wr(OFF_IRQ_MASK, 8'h02);
    bus_wr(OFF_TX_DATA, 8'h96);
    bus_wr(OFF_TX_DATA, 8'h3c);
    rd_chk(OFF_PIR, 8'h00, "tx full");
    bus_wr(OFF_TX_DATA, 8'hff);
    bus_wr(OFF_IRQ_STAT, 8'h07);
    sleep_i <= 1'b1;
    i_link_master.xfer(1'b0, 8'h00, v);
    chk_byte(v, 8'h96, "tx first");
    wait_wake();
    chk_bit(wake_o, 1'b1, "tx wake");
    chk_bit(irq_o, 1'b1, "tx irq");
    sleep_i <= 1'b0;
    rd_chk(OFF_PIR, 8'h10, "tx reload");
    bus_wr(OFF_TX_DATA, 8'h5a);
    rd_chk(OFF_PIR, 8'h00, "tx refill");
    i_link_master.xfer(1'b0, 8'h00, v);
    chk_byte(v, 8'h3c, "tx second");
    i_link_master.xfer(1'b0, 8'h00, v);
    chk_byte(v, 8'h5a, "tx third");
    $display("test tx done");
    bus_wr(OFF_TX_STAT, 8'h10);
    bus_wr(OFF_RX_STAT, 8'h90);
    bus_wr(OFF_ALT_PIN, 8'h06);
    bus_wr(OFF_BAUD, 8'h10);
    loc_q <= 1'b1;
    i_link_master.xfer(1'b1, 8'hc3, v);
    repeat (8) @(posedge clock_i);
    rd_chk(OFF_RX_DATA, 8'hc3, "alt pins");
    bus_wr(OFF_TX_STAT, 8'h00);
    i_link_master.xfer(1'b1, 8'h77, v);
    repeat (8) @(posedge clock_i);
    rd_chk(OFF_PIR, 8'h10, "async quiet");
    $display("test pins done");
    wrap_up();
  end
endmodule // test_sleep_serial
